// ---- core/watchdog_cfg.svh ----
// Constants for the runaway watchdog: register map, field layout, codes
// Assumes an AXI4-Lite register bus with 32-bit data
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WD_ADDR_W        12
`define WD_MODE_OFF      12'h300
`define WD_CMD_OFF       12'h304
`define WD_STS_OFF       12'h308
`define WD_MSK_OFF       12'h30C

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define WD_EN_BIT        7
`define WD_TP_HI         6
`define WD_TP_LO         5
`define WD_I2_BIT        2
`define WD_RC_BIT        1
`define WD_EN_RST        1'b1
`define WD_TP_RST        2'b00
`define WD_I2_RST        1'b0
`define WD_RC_RST        1'b0

// ----------------------------------------
// Command codes
// ----------------------------------------
`define WD_CODE_DISABLE  8'hB1
`define WD_CODE_CLEAR    8'h4E

// ----------------------------------------
// Status and mask bits
// ----------------------------------------
`define WD_EV_W          2
`define WD_EV_OVF        0
`define WD_EV_RST        1
`define WD_EV_RST_VAL    2'b00

// ----------------------------------------
// Counter and timing
// ----------------------------------------
`define WD_CNT_W         22
`define WD_TAP_BASE      15
`define WD_TAP_STEP      2
`define WD_GEAR_DIV      16
`define WD_SYS_PRE       2
`define WD_DIV_W         6
`define WD_RST_STATES    25
`define WD_RST_W         5

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define WD_RESP_OKAY     2'b00
`define WD_RESP_SLVERR   2'b10

`endif

// ---- core/watchdog_pkg.sv ----
// Types shared by the runaway watchdog
// Assumes watchdog_cfg.svh is on the include path
`include "watchdog_cfg.svh"

package watchdog_pkg;

	// ----------------------------------------
	// Whole state of the watchdog
	// ----------------------------------------
	typedef struct packed {
		logic                    aw_rdy;
		logic [`WD_ADDR_W-1:0]   aw_addr;
		logic                    w_rdy;
		logic [7:0]              w_data;
		logic                    w_lane0;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    ar_rdy;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic                    en;
		logic [1:0]              tp;
		logic                    i2;
		logic                    reset_connect_bit;
		logic                    running;
		logic [`WD_DIV_W-1:0]    div;
		logic [`WD_CNT_W-1:0]    cnt;
		logic [`WD_RST_W-1:0]    rst_cnt;
		logic                    rst_act;
		logic [`WD_EV_W-1:0]     sts;
		logic [`WD_EV_W-1:0]     msk;
		logic                    irq;
		logic                    nmi;
	} state_type;

endpackage

// ---- core/runaway_detector.sv ----
// Runaway watchdog with an AXI4-Lite register slave
// Assumes one 50 MHz clock, synchronous active-low reset, power mode levels
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "watchdog_cfg.svh"

module runaway_detector #(
	parameter int CNT_W      = `WD_CNT_W,
	parameter int TAP_BASE   = `WD_TAP_BASE,
	parameter int GEAR_DIV   = `WD_GEAR_DIV,
	parameter int RST_STATES = `WD_RST_STATES
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [`WD_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`WD_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  first_idle_mode,
	input  wire logic                  second_idle_mode,
	input  wire logic                  stop_mode,
	output logic                       runaway_nmi,
	output logic                       internal_chip_reset,
	output logic                       irq
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	localparam int TAP_TOP = TAP_BASE + 3 * `WD_TAP_STEP;
	localparam int SYS_DIV = GEAR_DIV * `WD_SYS_PRE;

	// Refused at elaboration, before any process runs
	if (CNT_W != `WD_CNT_W || TAP_TOP >= CNT_W || TAP_BASE < 1) begin : g_bad_taps
		$error("runaway_detector: counter width and taps do not fit");
	end
	if (SYS_DIV < 1 || SYS_DIV > (1 << `WD_DIV_W)) begin : g_bad_div
		$error("runaway_detector: clock divider out of range");
	end
	if (RST_STATES < 22 || RST_STATES > 29) begin : g_bad_rst
		$error("runaway_detector: internal reset length out of range");
	end

	localparam logic [`WD_DIV_W-1:0] DIV_LAST = `WD_DIV_W'(SYS_DIV - 1);
	localparam logic [`WD_RST_W-1:0] RST_LAST = `WD_RST_W'(RST_STATES - 1);

	watchdog_pkg::state_type s_r;
	watchdog_pkg::state_type s_nxt;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic                  tick;
		logic                  counting;
		logic                  ovf;
		logic                  do_write;
		logic [7:0]            wd;
		logic [CNT_W-1:0]      cnt_inc;
		logic [4:0]            tap;
		logic [`WD_EV_W-1:0]   ev_set;
		logic [`WD_EV_W-1:0]   ev_clr;
		tick     = 1'b0;
		counting = 1'b0;
		ovf      = 1'b0;
		do_write = 1'b0;
		wd       = 8'h00;
		cnt_inc  = '0;
		tap      = 5'h00;
		ev_set   = '0;
		ev_clr   = '0;
		s_nxt    = s_r;
		s_nxt.nmi = 1'b0;

		// Prescaler standing in for gear clock divided by two
		if (s_r.div == DIV_LAST) begin
			s_nxt.div = '0;
			tick      = 1'b1;
		end else begin
			s_nxt.div = s_r.div + `WD_DIV_W'(1);
		end

		// Power modes gate counting; second_idle_mode obeys its own bit
		counting = s_r.running && !first_idle_mode && !stop_mode
			&& !(second_idle_mode && !s_r.i2);

		// Tap overflow at 2^(15 + 2*select) prescaler ticks, 32 system clocks each
		tap     = 5'(TAP_BASE) + {2'b00, s_r.tp, 1'b0};
		cnt_inc = s_r.cnt + CNT_W'(1);
		if (tick && counting) begin
			ovf = cnt_inc[tap];
			if (ovf) begin
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = cnt_inc;
			end
		end
		if (ovf) begin
			s_nxt.nmi = 1'b1;
			ev_set[`WD_EV_OVF] = 1'b1;
		end

		// Internal reset pulse, counted in prescaler tick states
		if (ovf && s_r.reset_connect_bit && !s_r.rst_act) begin
			s_nxt.rst_act = 1'b1;
			s_nxt.rst_cnt = '0;
			ev_set[`WD_EV_RST] = 1'b1;
		end else if (s_r.rst_act && tick) begin
			if (s_r.rst_cnt == RST_LAST) begin
				s_nxt.rst_act = 1'b0;
			end else begin
				s_nxt.rst_cnt = s_r.rst_cnt + `WD_RST_W'(1);
			end
		end

		// ----------------------------------------
		// Write channel
		// ----------------------------------------
		if (s_r.aw_rdy && s_axi_awvalid) begin
			s_nxt.aw_rdy  = 1'b0;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_r.w_rdy && s_axi_wvalid) begin
			s_nxt.w_rdy   = 1'b0;
			s_nxt.w_data  = s_axi_wdata[7:0];
			s_nxt.w_lane0 = s_axi_wstrb[0];
		end
		if (!s_r.aw_rdy && !s_r.w_rdy && !s_r.bvalid) begin
			do_write     = s_r.w_lane0;
			wd           = s_r.w_data;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = `WD_RESP_OKAY;
			if (s_r.aw_addr == `WD_MODE_OFF) begin
				if (do_write) begin
					s_nxt.en    = wd[`WD_EN_BIT];
					s_nxt.tp    = wd[`WD_TP_HI:`WD_TP_LO];
					s_nxt.i2    = wd[`WD_I2_BIT];
					s_nxt.reset_connect_bit = wd[`WD_RC_BIT];
					if (wd[`WD_EN_BIT])
						s_nxt.running = 1'b1;
				end
			end else if (s_r.aw_addr == `WD_CMD_OFF) begin
				if (do_write && wd == `WD_CODE_CLEAR) begin
					s_nxt.cnt = '0;
				end else if (do_write && wd == `WD_CODE_DISABLE && !s_r.en) begin
					s_nxt.running = 1'b0;
				end
				// Any other code leaves everything as it was
			end else if (s_r.aw_addr == `WD_STS_OFF) begin
				if (do_write)
					ev_clr = wd[`WD_EV_W-1:0];
			end else if (s_r.aw_addr == `WD_MSK_OFF) begin
				if (do_write)
					s_nxt.msk = wd[`WD_EV_W-1:0];
			end else begin
				s_nxt.bresp = `WD_RESP_SLVERR;
			end
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_rdy = 1'b1;
			s_nxt.w_rdy  = 1'b1;
		end

		// New events win over a clear in the same cycle
		s_nxt.sts = (s_r.sts & ~ev_clr) | ev_set;
		s_nxt.irq = |(s_nxt.sts & s_nxt.msk);

		// ----------------------------------------
		// Read channel
		// ----------------------------------------
		if (s_r.ar_rdy && s_axi_arvalid) begin
			s_nxt.ar_rdy = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = 32'h0000_0000;
			s_nxt.rresp  = `WD_RESP_OKAY;
			if (s_axi_araddr == `WD_MODE_OFF) begin
				s_nxt.rdata[`WD_EN_BIT]          = s_r.en;
				s_nxt.rdata[`WD_TP_HI:`WD_TP_LO] = s_r.tp;
				s_nxt.rdata[`WD_I2_BIT]          = s_r.i2;
				s_nxt.rdata[`WD_RC_BIT]          = s_r.reset_connect_bit;
			end else if (s_axi_araddr == `WD_CMD_OFF) begin
				// Write-only command register reads as zero
				s_nxt.rdata = 32'h0000_0000;
			end else if (s_axi_araddr == `WD_STS_OFF) begin
				s_nxt.rdata[`WD_EV_W-1:0] = s_r.sts;
			end else if (s_axi_araddr == `WD_MSK_OFF) begin
				s_nxt.rdata[`WD_EV_W-1:0] = s_r.msk;
			end else begin
				s_nxt.rresp = `WD_RESP_SLVERR;
			end
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.ar_rdy = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r         <= '0;
			s_r.aw_rdy  <= 1'b1;
			s_r.w_rdy   <= 1'b1;
			s_r.ar_rdy  <= 1'b1;
			s_r.en      <= `WD_EN_RST;
			s_r.running <= `WD_EN_RST;
			s_r.tp      <= `WD_TP_RST;
			s_r.i2      <= `WD_I2_RST;
			s_r.reset_connect_bit   <= `WD_RC_RST;
			s_r.sts     <= `WD_EV_RST_VAL;
			s_r.msk     <= `WD_EV_RST_VAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready = s_r.aw_rdy;
	assign s_axi_wready  = s_r.w_rdy;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_r.ar_rdy;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign runaway_nmi   = s_r.nmi;
	// Only the internal reset; no pin toward the board exists
	assign internal_chip_reset = s_r.rst_act;
	assign irq           = s_r.irq;

endmodule

// ---- test/runaway_detector_checker.sv ----
// Assertions on the watchdog ports
// Bound into every runaway_detector
`timescale 1ns/100ps
module runaway_detector_checker #(
	parameter int GEAR_DIV = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic first_idle_mode,
	input wire logic stop_mode,
	input wire logic runaway_nmi,
	input wire logic internal_chip_reset
);
	logic [15:0] len_r;
	logic [15:0] len_nxt;
	// Slack of one state at each end keeps a partial tick legal
	always_comb len_nxt = internal_chip_reset ? len_r + 16'h0001 : 16'h0000;
	always_ff @(posedge aclk) len_r <= aresetn ? len_nxt : 16'h0000;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_nmi_gap: assert property (runaway_nmi |=> !runaway_nmi [*8])
		else $error("nmi gap");
	a_halt_nmi: assert property ($past(first_idle_mode) || $past(stop_mode) |-> !runaway_nmi)
		else $error("nmi while halted");
	a_rst_cause: assert property ($rose(internal_chip_reset) |->
		$past(runaway_nmi) || runaway_nmi) else $error("reset without nmi");
	a_rst_short: assert property ($fell(internal_chip_reset) |-> len_r >= 16'(42 * GEAR_DIV))
		else $error("reset short");
	a_rst_long: assert property (len_r <= 16'(60 * GEAR_DIV))
		else $error("reset long");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data");
	a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not closed");
	a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write not closed");
endmodule

bind runaway_detector runaway_detector_checker #(.GEAR_DIV(GEAR_DIV))
	runaway_detector_checker_inst (.*);

// ---- test/test_runaway_detector.sv ----
// Self-checking bench for the runaway watchdog
// Drives the bus and power mode levels directly
`timescale 1ns/100ps
`include "watchdog_cfg.svh"
module test_runaway_detector;
	localparam int GD = 1;
	localparam int TB = 3;
	logic        aclk = 1'b0;
	logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, irq;
	logic        s_axi_rready, first_idle_mode, second_idle_mode, stop_mode, runaway_nmi;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        internal_chip_reset;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          failures = 0, n_checks = 0, cyc = 0, nmis = 0, n;
	// Short divider and taps keep the run brief
	runaway_detector #(.TAP_BASE(TB), .GEAR_DIV(GD)) runaway_detector_inst (.*);
	always #10 aclk = ~aclk;
	// Counted mid-cycle, clear of stimulus edges
	always @(negedge aclk) begin
		cyc++;
		nmis += (runaway_nmi === 1'b1);
		if (cyc == 10000) begin
			failures++;
			final_report();
		end
	end
	// --------
	// Tasks
	// --------
	task automatic final_report();
		$display("%0d checks, %0d failures", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(`WD_CMD_OFF, {24'h00_0000, c});
	endtask
	task automatic mode(input logic [7:0] v);
		wr(`WD_MODE_OFF, {24'h00_0000, v});
	endtask
	// Cycles between two overflow pulses
	task automatic period(output int p);
		do @(posedge aclk); while (runaway_nmi !== 1'b1);
		p = 0;
		do begin
			@(posedge aclk);
			p++;
		end while (runaway_nmi !== 1'b1);
	endtask
	// --------
	// Tests
	// --------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{first_idle_mode, second_idle_mode, stop_mode} = 3'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h00_0000_0000_0000;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		period(n);
		check("period", 16 * GD, n);
		rd_reg(`WD_MODE_OFF, rd);
		check("mode", 32'h0000_0080, rd);
		$display("reset test done");
		for (int s = 0; s < 4; s++) begin
			mode(8'h80 | 8'(s << 5));
			cmd(8'h4E);
			period(n);
			check("period", 2 * GD << (TB + 2 * s), n);
		end
		$display("tap test done");
		cmd(8'h4E);
		mode(8'h80);
		n = nmis;
		repeat (6) begin
			cmd(8'h4E);
			idle(6);
		end
		check("cleared nmis", n, nmis);
		for (int i = 0; i < 6; i++) begin
			cmd(i[0] ? 8'hB1 : 8'h55);
			idle(6);
		end
		check("other codes", 1, nmis > n);
		for (int m = 0; m < 4; m++) begin
			mode(m == 3 ? 8'h84 : 8'h80);
			cmd(8'h4E);
			{first_idle_mode, second_idle_mode, stop_mode} <= {m == 0, m[0], m == 2};
			n = nmis;
			idle(40);
			check("low power nmis", m == 3, nmis > n);
			{first_idle_mode, second_idle_mode, stop_mode} <= 3'h0;
		end
		$display("command test done");
		cmd(8'h4E);
		mode(8'h82);
		check("write resp", `WD_RESP_OKAY, resp);
		do @(posedge aclk); while (internal_chip_reset !== 1'b1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (internal_chip_reset === 1'b1);
		check("reset span", 1, n >= 44 * GD && n <= 58 * GD);
		rd_reg(`WD_STS_OFF, rd);
		check("reset status", 32'h0000_0003, rd);
		check("read resp", `WD_RESP_OKAY, resp);
		mode(8'h00);
		cmd(8'hB1);
		wr(`WD_STS_OFF, 32'h0000_0003);
		wr(`WD_MSK_OFF, 32'h0000_0001);
		mode(8'h80);
		idle(30);
		check("irq", 1, irq);
		wr(`WD_MSK_OFF, 32'h0000_0000);
		idle(2);
		check("masked irq", 0, irq);
		mode(8'h00);
		cmd(8'hB1);
		n = nmis;
		rd_reg(`WD_STS_OFF, rd);
		check("status", 32'h0000_0001, rd);
		idle(40);
		check("disabled nmis", n, nmis);
		wr(`WD_MSK_OFF, 32'h0000_0001);
		wr(`WD_STS_OFF, 32'h0000_0001);
		idle(2);
		check("cleared irq", 0, irq);
		wr(12'h310, 32'h0000_0001);
		check("unmapped", `WD_RESP_SLVERR, resp);
		$display("irq test done");
		final_report();
	end
endmodule
